/* File: logic/xdle_top.sv */
// execute stage for xor literal, xor file and direction load
// assumes file register read data arrives combinationally for file_addr_o
`timescale 1ns/1ps
module xdle_top
    import xdle_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    // instruction stream
    input  wire logic               instr_valid_i,
    input  wire logic [XDLE_IW-1:0] instr_i,
    // file register read
    input  wire logic [XDLE_DW-1:0] file_rdata_i,
    // direct direction register access
    input  wire logic               dir_we_i,
    input  wire logic [2:0]         dir_sel_i,
    input  wire logic [XDLE_DW-1:0] dir_wdata_i,
    output logic      [XDLE_DW-1:0] dir_rdata_o,
    // file register write
    output logic                    file_we_o,
    output logic      [XDLE_AW-1:0] file_waddr_o,
    output logic      [XDLE_DW-1:0] file_wdata_o,
    // state and combinational file read address
    output logic      [XDLE_DW-1:0] w_o,
    output logic                    zero_o,
    output logic      [XDLE_DW-1:0] dir5_o,
    output logic      [XDLE_DW-1:0] dir6_o,
    output logic      [XDLE_DW-1:0] dir7_o,
    output logic      [XDLE_AW-1:0] file_addr_o
);
    import xdle_pkg::*;

    xdle_op_e            op;
    logic [XDLE_DW-1:0]  res;
    logic                dest;
    logic [XDLE_DW-1:0]  dir_q [XDLE_NDIR];
    logic                dir_ok;

    xdle_decode u_dec (
        .instr_i (instr_i),
        .op_o    (op)
    );

    // read address is the file field, presented combinationally
    assign file_addr_o = instr_i[XDLE_AW-1:0];
    assign dest        = instr_i[XDLE_DEST_BIT];
    assign dir_ok      = (instr_i[2:0] >= XDLE_DIR_MIN)
                       && (instr_i[2:0] <= XDLE_DIR_MAX);

    always_comb begin
        res = w_o;
        unique case (op)
            XDLE_OP_XORLIT: res = w_o ^ instr_i[XDLE_DW-1:0];
            XDLE_OP_XORF:   res = w_o ^ file_rdata_i;
            XDLE_OP_DIRLD:  res = w_o;
            XDLE_OP_NONE:   res = w_o;
        endcase
    end

    // working register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_o <= XDLE_W_RST;
        end else if (instr_valid_i) begin
            if (op == XDLE_OP_XORLIT) begin
                w_o <= res;
            end else if (op == XDLE_OP_XORF && !dest) begin
                w_o <= res;
            end
        end
    end

    // zero flag, untouched by direction load
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            zero_o <= 1'b0;
        end else if (instr_valid_i
                     && (op == XDLE_OP_XORLIT || op == XDLE_OP_XORF)) begin
            zero_o <= (res == '0);
        end
    end

    // file write back
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            file_we_o    <= 1'b0;
            file_waddr_o <= '0;
            file_wdata_o <= '0;
        end else begin
            file_we_o <= instr_valid_i && op == XDLE_OP_XORF && dest;
            file_waddr_o <= instr_i[XDLE_AW-1:0];
            file_wdata_o <= res;
        end
    end

    // direction registers, instruction load has priority over direct write
    genvar gi;
    generate
        for (gi = 0; gi < XDLE_NDIR; gi++) begin : g_dir
            localparam logic [2:0] SEL = XDLE_DIR_MIN + 3'(gi);
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    dir_q[gi] <= XDLE_DIR_RST;
                end else if (instr_valid_i && op == XDLE_OP_DIRLD
                             && dir_ok && instr_i[2:0] == SEL) begin
                    dir_q[gi] <= w_o;
                end else if (dir_we_i && dir_sel_i == SEL) begin
                    dir_q[gi] <= dir_wdata_i;
                end
            end
        end
    endgenerate

    assign dir5_o = dir_q[0];
    assign dir6_o = dir_q[1];
    assign dir7_o = dir_q[2];

    // registered readback
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_rdata_o <= '0;
        end else if (dir_sel_i >= XDLE_DIR_MIN) begin
            dir_rdata_o <= dir_q[2'(dir_sel_i - XDLE_DIR_MIN)];
        end else begin
            dir_rdata_o <= '0;
        end
    end
endmodule : xdle_top

/* File: logic/xdle_pkg.sv */
// package for the xor and direction load execute block
// constants shared by decoder and top
package xdle_pkg;
    localparam int        XDLE_IW        = 14;
    localparam int        XDLE_DW        = 8;
    localparam int        XDLE_AW        = 7;
    localparam int        XDLE_NDIR      = 3;
    // opcode patterns and masks
    localparam logic [13:0] XDLE_XORLIT_MASK = 14'h3f00;
    localparam logic [13:0] XDLE_XORLIT_PAT  = 14'h3a00;
    localparam logic [13:0] XDLE_XORF_MASK   = 14'h3f00;
    localparam logic [13:0] XDLE_XORF_PAT    = 14'h0600;
    localparam logic [13:0] XDLE_DIRLD_MASK  = 14'h3ff8;
    localparam logic [13:0] XDLE_DIRLD_PAT   = 14'h0060;
    // field positions
    localparam int        XDLE_DEST_BIT  = 7;
    // direction register selector range
    localparam logic [2:0] XDLE_DIR_MIN  = 3'h5;
    localparam logic [2:0] XDLE_DIR_MAX  = 3'h7;
    // reset values
    localparam logic [7:0] XDLE_W_RST    = 8'h00;
    localparam logic [7:0] XDLE_DIR_RST  = 8'hff;
    typedef enum logic [1:0] {
        XDLE_OP_NONE,
        XDLE_OP_XORLIT,
        XDLE_OP_XORF,
        XDLE_OP_DIRLD
    } xdle_op_e;
endpackage : xdle_pkg

/* File: logic/xdle_decode.sv */
// combinational opcode classifier
// assumes a 14-bit instruction word from fetch, same clock domain
`timescale 1ns/1ps
module xdle_decode
    import xdle_pkg::*;
(
    // instruction
    input  wire logic [XDLE_IW-1:0] instr_i,
    // decoded class
    output xdle_op_e                op_o
);
    always_comb begin
        op_o = XDLE_OP_NONE;
        if ((instr_i & XDLE_XORLIT_MASK) == XDLE_XORLIT_PAT) begin
            op_o = XDLE_OP_XORLIT;
        end else if ((instr_i & XDLE_XORF_MASK) == XDLE_XORF_PAT) begin
            op_o = XDLE_OP_XORF;
        end else if ((instr_i & XDLE_DIRLD_MASK) == XDLE_DIRLD_PAT) begin
            op_o = XDLE_OP_DIRLD;
        end
    end
endmodule : xdle_decode

/* File: tb/xdle_props.sv */
// checker for the xor and direction load execute block
// assumes it is bound to xdle_top, one clock domain
`timescale 1ns/1ps
module xdle_props (
    input wire logic        clk_i, reset_n_i, instr_valid_i, dir_we_i,
    input wire logic        file_we_o, zero_o,
    input wire logic [13:0] instr_i,
    input wire logic [7:0]  file_rdata_i, dir_wdata_i, w_o, file_wdata_o,
    input wire logic [7:0]  dir5_o, dir7_o,
    input wire logic [6:0]  file_waddr_o,
    input wire logic [2:0]  dir_sel_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence xorlit_s; instr_valid_i && instr_i[13:8] == 6'h3a; endsequence
    sequence xorf_s; instr_valid_i && instr_i[13:8] == 6'h06; endsequence
    sequence dirld_s; instr_valid_i && instr_i[13:3] == 11'h00c; endsequence
    a_xorlit_w: assert property (xorlit_s |=>
        w_o == ($past(w_o) ^ $past(instr_i[7:0])) && zero_o == (w_o == 8'h00))
        else $error("xor literal result wrong");
    a_xorlit_only_w: assert property (xorlit_s |=> !file_we_o
        && dir5_o == (($past(dir_we_i) && $past(dir_sel_i) == 3'h5)
        ? $past(dir_wdata_i) : $past(dir5_o)))
        else $error("xor literal touched more than w");
    a_dirld_copy: assert property (dirld_s ##0 instr_i[2:0] == 3'h7 |=>
        dir7_o == $past(w_o) && $stable(zero_o)) else $error("dir load wrong");
    a_dir_direct: assert property (
        dir_we_i && dir_sel_i == 3'h5 && !instr_valid_i |=>
        dir5_o == $past(dir_wdata_i)) else $error("direct dir write lost");
    a_xorf_dest: assert property (xorf_s ##0 instr_i[7] |=> file_we_o &&
        file_wdata_o == ($past(w_o) ^ $past(file_rdata_i)) &&
        file_waddr_o == $past(instr_i[6:0]) && $stable(w_o))
        else $error("xor file write wrong");
endmodule : xdle_props

/* File: tb/test_xdle_top.sv */
// testbench for the xor and direction load execute block
// assumes xdle_pkg, xdle_top and xdle_props are compiled first
`timescale 1ns/1ps
module test_xdle_top;
    import xdle_pkg::*;
    logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0, dir_we_i = 0;
    logic [13:0] instr_i = '0;
    logic [7:0] file_rdata_i = '0, dir_wdata_i = '0, mw = '0, mfd, k;
    logic [2:0] dir_sel_i = '0;
    logic [7:0] w_o, dir5_o, dir6_o, dir7_o, file_wdata_o, md [8];
    logic [7:0] dir_rdata_o;
    logic [6:0] file_waddr_o, file_addr_o;
    logic file_we_o, zero_o, mz = 0, mfw;
    logic [63:0] exp_v, got_v, notes [$];
    int num_errors = 0, checked = 0, op;
    xdle_top dut (.clk_i, .reset_n_i, .instr_valid_i, .instr_i, .file_rdata_i,
        .dir_we_i, .dir_sel_i, .dir_wdata_i, .dir_rdata_o, .file_we_o,
        .file_waddr_o, .file_wdata_o, .w_o, .zero_o, .dir5_o, .dir6_o,
        .dir7_o, .file_addr_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic step(input logic v, input logic [13:0] ins, input logic we);
        logic [7:0] r;
        logic [7:0] rd;
        @(negedge clk_i);
        instr_valid_i = v; instr_i = ins; dir_we_i = we;
        dir_sel_i = k[2:0]; dir_wdata_i = ~k;
        file_rdata_i = k[1] ? k : mw;
        r = mw ^ file_rdata_i; mfw = 0; mfd = '0;
        rd = (k[2:0] >= 3'h5) ? md[k[2:0]] : 8'h00;
        if (we && k[2:0] >= 3'h5) md[k[2:0]] = ~k;
        if (v && ins[13:8] == 6'h3a) begin
            mw = mw ^ ins[7:0]; mz = (mw == 8'h00);
        end else if (v && ins[13:8] == 6'h06) begin
            mz = (r == 8'h00);
            if (ins[7]) begin mfw = 1; mfd = r; end else mw = r;
        end else if (v && ins[13:3] == 11'h00c && ins[2:0] >= 3'h5)
            md[ins[2:0]] = mw;
        notes.push_back({mw, mz, mfw, mfd, mfw ? ins[6:0] : 7'h00,
            md[5], md[6], md[7], rd, ins[6:0]});
    endtask : step
    always @(posedge clk_i) if (reset_n_i && notes.size() > 0) begin
        #1;
        exp_v = notes.pop_front();
        got_v = {w_o, zero_o, file_we_o, file_wdata_o & {8{file_we_o}},
            file_waddr_o & {7{file_we_o}}, dir5_o, dir6_o, dir7_o,
            dir_rdata_o, file_addr_o};
        checked++;
        if (got_v !== exp_v) begin
            num_errors++;
            $display("wrong value state exp %h got %h", exp_v, got_v);
        end
    end
    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        foreach (md[i]) md[i] = 8'hff;
        k = $urandom(32'h8fbc);
        repeat (16) @(negedge clk_i);
        reset_n_i = 1;
        step(1, 14'h3fff, 0);
        step(1, 14'h3ab5, 0);
        step(1, 14'h3aaf, 0);
        step(1, 14'h3a1a, 0);
        repeat (400) begin
            op = $urandom % 4; k = $urandom;
            step(op == 3 ? k[3] : 1'b1, op == 0 ? {6'h3a, k} : op == 1 ?
                {6'h06, k} : op == 2 ? {11'h00c, k[2:0]} : {k, k[5:0]},
                k[4]);
        end
        step(0, 14'h0000, 0);
        @(negedge clk_i);
        tally_and_finish();
    end
endmodule : test_xdle_top
bind xdle_top xdle_props u_props (.clk_i, .reset_n_i, .instr_valid_i,
    .dir_we_i, .file_we_o, .zero_o, .instr_i, .file_rdata_i, .dir_wdata_i,
    .w_o, .file_wdata_o, .dir5_o, .dir7_o, .file_waddr_o, .dir_sel_i);
